// [src/dfct_pkg.sv]
// Constants, register map and stage type of the closed-loop frequency tuner.
// Assumes a 32-bit APB slave with byte addresses and one register per word.
package dfct_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] DFCT_OFS_CTRL    = 8'h00;
    localparam logic [7:0] DFCT_OFS_MUL     = 8'h04;
    localparam logic [7:0] DFCT_OFS_VAL     = 8'h08;
    localparam logic [7:0] DFCT_OFS_STATUS  = 8'h0C;
    localparam logic [7:0] DFCT_OFS_IRQSET  = 8'h10;
    localparam logic [7:0] DFCT_OFS_IRQCLR  = 8'h14;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int DFCT_CTRL_W          = 7;
    localparam int DFCT_CTRL_ENABLE     = 0;
    localparam int DFCT_CTRL_CLOSED     = 1;
    localparam int DFCT_CTRL_HOLD       = 2;
    localparam int DFCT_CTRL_CHILLDIS   = 3;
    localparam int DFCT_CTRL_QLDIS      = 4;
    localparam int DFCT_CTRL_DROPLOCK   = 5;
    localparam int DFCT_CTRL_BYPASS     = 6;
    localparam logic [6:0] DFCT_CTRL_RST = 7'h00;

    // ----------------------------------------------------------------
    // Multiplier and value register fields
    // ----------------------------------------------------------------
    localparam int DFCT_ROUGH_W         = 6;
    localparam int DFCT_TRIM_W          = 10;
    localparam int DFCT_RATIO_W         = 16;
    localparam int DFCT_MUL_RATIO_LSB   = 0;
    localparam int DFCT_MUL_TSTEP_LSB   = 16;
    localparam int DFCT_MUL_RSTEP_LSB   = 26;
    localparam logic [31:0] DFCT_MUL_RST = 32'h0000_0000;
    localparam int DFCT_VAL_TRIM_LSB    = 0;
    localparam int DFCT_VAL_ROUGH_LSB   = 10;
    localparam int DFCT_VAL_ERR_LSB     = 16;
    localparam logic [5:0] DFCT_ROUGH_RST = 6'h1F;
    localparam logic [9:0] DFCT_TRIM_RST  = 10'h1FF;

    // ----------------------------------------------------------------
    // Status and interrupt enable bits
    // ----------------------------------------------------------------
    localparam int DFCT_ST_READY        = 0;
    localparam int DFCT_ST_REFSTOP      = 1;
    localparam int DFCT_ST_OOB          = 2;
    localparam int DFCT_ST_TRIMLOCK     = 3;
    localparam int DFCT_ST_ROUGHLOCK    = 4;
    localparam int DFCT_IE_ROUGH        = 0;
    localparam int DFCT_IE_TRIM         = 1;
    localparam int DFCT_IE_REFSTOP      = 2;

    // ----------------------------------------------------------------
    // Timing and tolerances
    // ----------------------------------------------------------------
    localparam logic [3:0] DFCT_START_CYCLES = 4'h8;
    localparam int DFCT_REF_STOP_CYCLES      = 131072;
    localparam logic [18:0] DFCT_ROUGH_TOL   = 19'h00020;
    localparam logic [18:0] DFCT_TRIM_TOL    = 19'h00001;

    typedef enum logic [1:0] {
        DFCT_OPEN,
        DFCT_ROUGH,
        DFCT_TRIM
    } dfct_stage_e;

endpackage

// [src/dfct_tuner.sv]
// Closed-loop tuner of a digital frequency-locked loop, with its APB registers.
// Assumes clock is the loop's own output clock and that the reference level
// arrives synchronous to it from generic clock channel zero.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

module dfct_tuner
    import dfct_pkg::*;
#(
    parameter int REF_STOP_CYCLES = dfct_pkg::DFCT_REF_STOP_CYCLES
) (
    input  wire logic                              clock,
    input  wire logic                              rst,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [7:0]                        paddr,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire logic                              tunerReferenceClock,
    output logic                                   oscEnable,
    output logic      [dfct_pkg::DFCT_ROUGH_W-1:0] roughTuneValue,
    output logic      [dfct_pkg::DFCT_TRIM_W-1:0]  trimTuneValue,
    output logic                                   irqRequest
);
    import dfct_pkg::*;

    localparam int CNT_W = 18;
    localparam logic [CNT_W-1:0] STOP_CNT = CNT_W'(REF_STOP_CYCLES);

    typedef struct packed {
        dfct_stage_e              stage;
        logic                     refPrev;
        logic [CNT_W-1:0]         periodCnt;
        logic                     measValid;
        logic                     chill;
        logic                     lastFast;
        logic [DFCT_ROUGH_W-1:0]  rough;
        logic [DFCT_TRIM_W-1:0]   trim;
        logic [DFCT_ROUGH_W-1:0]  roughStep;
        logic [DFCT_TRIM_W-1:0]   trimStep;
        logic [DFCT_RATIO_W-1:0]  ratioErr;
        logic                     roughLocked;
        logic                     trimLocked;
        logic                     oob;
        logic                     refStopped;
        logic                     ready;
        logic [3:0]               startCnt;
        logic [DFCT_CTRL_W-1:0]   ctrl;
        logic [31:0]              mul;
        logic [2:0]               irqEn;
        logic [31:0]              prdata;
        logic                     irq;
        logic                     prevClosed;
        logic                     prevEn;
    } dfct_state_s;

    dfct_state_s s;
    dfct_state_s next_s;

    logic                    setup;
    logic                    access;
    logic                    hit;
    logic                    en;
    logic                    closed;
    logic                    refEdge;
    logic signed [CNT_W:0]   diff;
    logic        [CNT_W:0]   mag;
    logic                    fast;
    logic        [CNT_W:0]   roughTol;
    logic        [CNT_W:0]   trimTol;
    logic        [DFCT_TRIM_W:0] trimSum;
    logic        [DFCT_TRIM_W:0] trimDif;
    logic        [DFCT_ROUGH_W-1:0] rStepMax;
    logic        [DFCT_TRIM_W-1:0]  tStepMax;
    logic                    adjust;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    always_comb begin
        setup  = psel & ~penable;
        access = psel & penable;
        hit    = (paddr == DFCT_OFS_CTRL) | (paddr == DFCT_OFS_MUL) | (paddr == DFCT_OFS_VAL) |
                 (paddr == DFCT_OFS_STATUS) | (paddr == DFCT_OFS_IRQSET) | (paddr == DFCT_OFS_IRQCLR);
    end

    assign pready  = access;
    assign pslverr = access & ~hit;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_s   = s;
        en       = s.ctrl[DFCT_CTRL_ENABLE];
        closed   = s.ctrl[DFCT_CTRL_CLOSED];
        refEdge  = tunerReferenceClock & ~s.refPrev;
        diff     = $signed({1'b0, s.periodCnt}) -
                   $signed({3'b000, s.mul[DFCT_MUL_RATIO_LSB +: DFCT_RATIO_W]});
        mag      = diff[CNT_W] ? (CNT_W+1)'(-diff) : diff;
        fast     = ~diff[CNT_W] & (diff != '0);
        // Quick lock doubles the window; less settling, wider spread
        roughTol = s.ctrl[DFCT_CTRL_QLDIS] ? DFCT_ROUGH_TOL : DFCT_ROUGH_TOL << 1;
        trimTol  = s.ctrl[DFCT_CTRL_QLDIS] ? DFCT_TRIM_TOL : DFCT_TRIM_TOL << 1;
        rStepMax = (s.mul[DFCT_MUL_RSTEP_LSB +: DFCT_ROUGH_W] == '0) ? DFCT_ROUGH_W'(1) :
                   s.mul[DFCT_MUL_RSTEP_LSB +: DFCT_ROUGH_W];
        tStepMax = (s.mul[DFCT_MUL_TSTEP_LSB +: DFCT_TRIM_W] == '0) ? DFCT_TRIM_W'(1) :
                   s.mul[DFCT_MUL_TSTEP_LSB +: DFCT_TRIM_W];
        trimSum  = {1'b0, s.trim} + {1'b0, s.trimStep};
        trimDif  = {1'b0, s.trim} - {1'b0, s.trimStep};
        adjust   = 1'b0;

        next_s.irq        = 1'b0;
        next_s.refPrev    = tunerReferenceClock;
        next_s.prevClosed = closed;
        next_s.prevEn     = en;

        // ------------------------------------------------------------
        // Register bus
        // ------------------------------------------------------------
        if (setup) begin
            case (paddr)
                DFCT_OFS_CTRL:   next_s.prdata = {25'h0000000, s.ctrl};
                DFCT_OFS_MUL:    next_s.prdata = s.mul;
                DFCT_OFS_VAL:    next_s.prdata = {s.ratioErr, s.rough, s.trim};
                DFCT_OFS_STATUS: next_s.prdata = {27'h0000000, s.roughLocked, s.trimLocked,
                                                  s.oob, s.refStopped, s.ready};
                DFCT_OFS_IRQSET: next_s.prdata = {29'h00000000, s.irqEn};
                DFCT_OFS_IRQCLR: next_s.prdata = {29'h00000000, s.irqEn};
                default:         next_s.prdata = 32'h0000_0000;
            endcase
        end
        if (access && pwrite) begin
            case (paddr)
                DFCT_OFS_CTRL:   next_s.ctrl = pwdata[DFCT_CTRL_W-1:0];
                DFCT_OFS_MUL:    next_s.mul  = pwdata;
                DFCT_OFS_VAL: begin
                    if (!closed) begin
                        next_s.trim  = pwdata[DFCT_VAL_TRIM_LSB +: DFCT_TRIM_W];
                        next_s.rough = pwdata[DFCT_VAL_ROUGH_LSB +: DFCT_ROUGH_W];
                    end
                end
                DFCT_OFS_STATUS: begin
                    if (pwdata[DFCT_ST_OOB]) begin
                        next_s.oob = 1'b0;
                    end
                end
                DFCT_OFS_IRQSET: next_s.irqEn = s.irqEn | pwdata[2:0];
                DFCT_OFS_IRQCLR: next_s.irqEn = s.irqEn & ~pwdata[2:0];
                default: ;
            endcase
        end

        // ------------------------------------------------------------
        // Oscillator start-up and ready
        // ------------------------------------------------------------
        if (!en) begin
            next_s.startCnt = 4'h0;
            next_s.ready    = 1'b0;
        end else if (s.startCnt != DFCT_START_CYCLES) begin
            next_s.startCnt = s.startCnt + 4'h1;
        end else begin
            next_s.ready = 1'b1;
        end

        // ------------------------------------------------------------
        // Mode changes
        // ------------------------------------------------------------
        if (closed && !s.prevClosed) begin
            // Rough value as left by software is the search start
            next_s.stage       = s.ctrl[DFCT_CTRL_BYPASS] ? DFCT_TRIM : DFCT_ROUGH;
            next_s.roughLocked = s.ctrl[DFCT_CTRL_BYPASS];
            next_s.trimLocked  = 1'b0;
            next_s.roughStep   = rStepMax;
            next_s.trimStep    = tStepMax;
            next_s.measValid   = 1'b0;
            next_s.chill       = 1'b0;
            // Count restarts so no stale period trips the stop detector
            next_s.periodCnt   = '0;
        end else if (!closed) begin
            next_s.stage       = DFCT_OPEN;
            next_s.roughLocked = 1'b0;
            next_s.trimLocked  = 1'b0;
            next_s.refStopped  = 1'b0;
            next_s.measValid   = 1'b0;
        end else if (s.prevEn && !en) begin
            next_s.measValid = 1'b0;
            if (s.ctrl[DFCT_CTRL_DROPLOCK]) begin
                next_s.stage       = DFCT_ROUGH;
                next_s.roughLocked = 1'b0;
                next_s.trimLocked  = 1'b0;
                next_s.roughStep   = rStepMax;
                next_s.trimStep    = tStepMax;
            end
            // Otherwise stage and locks are simply kept
        end else if (en && !s.prevEn) begin
            // Stop count cleared on wake; below, a reference edge sets 1 and a running count carries on, but a count at the stop value stays cleared
            next_s.periodCnt = '0;
        end

        // ------------------------------------------------------------
        // Reference period measurement and stop detection
        // ------------------------------------------------------------
        if (en && closed && s.prevClosed) begin
            if (refEdge) begin
                next_s.periodCnt  = CNT_W'(1);
                next_s.measValid  = ~s.refStopped;
                next_s.refStopped = 1'b0;
            end else if (s.periodCnt != STOP_CNT) begin
                next_s.periodCnt = s.periodCnt + CNT_W'(1);
            end else begin
                next_s.refStopped = 1'b1;
                next_s.measValid  = 1'b0;
            end

            // Tuning only on a valid period; frozen while reference stopped
            if (refEdge && s.measValid && !s.refStopped && s.ready) begin
                next_s.ratioErr = (diff > $signed(19'sh07FFF)) ? 16'h7FFF :
                                  (diff < $signed(-19'sh08000)) ? 16'h8000 : diff[15:0];
                if (s.chill && !s.ctrl[DFCT_CTRL_CHILLDIS]) begin
                    // Skipped sample lets the oscillator settle after a change
                    next_s.chill = 1'b0;
                end else if (s.stage == DFCT_ROUGH) begin
                    if (mag <= roughTol ||
                        (fast && s.rough == '0) || (!fast && s.rough == '1)) begin
                        // A pinned rough value locks too: output stays at the floor or the ceiling
                        next_s.roughLocked = 1'b1;
                        next_s.stage       = DFCT_TRIM;
                        next_s.trimStep    = tStepMax;
                    end else begin
                        adjust = 1'b1;
                        if (fast) begin
                            next_s.rough = (s.rough > s.roughStep) ? s.rough - s.roughStep : '0;
                        end else begin
                            next_s.rough = (DFCT_ROUGH_W'('1) - s.rough > s.roughStep) ?
                                           s.rough + s.roughStep : '1;
                        end
                        if (fast != s.lastFast && s.roughStep > DFCT_ROUGH_W'(1)) begin
                            next_s.roughStep = s.roughStep >> 1;
                        end
                    end
                end else if (s.stage == DFCT_TRIM) begin
                    if (mag <= trimTol && !s.trimLocked) begin
                        next_s.trimLocked = 1'b1;
                        next_s.trimStep   = DFCT_TRIM_W'(1);
                    end else if (s.trimLocked) begin
                        adjust = ~s.ctrl[DFCT_CTRL_HOLD] & (diff != '0);
                    end else begin
                        adjust = 1'b1;
                        if (fast != s.lastFast && s.trimStep > DFCT_TRIM_W'(1)) begin
                            next_s.trimStep = s.trimStep >> 1;
                        end
                    end
                    if (adjust) begin
                        if (fast) begin
                            if (trimDif[DFCT_TRIM_W]) begin
                                next_s.trim = '0;
                                next_s.oob  = 1'b1;
                            end else begin
                                next_s.trim = trimDif[DFCT_TRIM_W-1:0];
                            end
                        end else begin
                            if (trimSum[DFCT_TRIM_W]) begin
                                next_s.trim = '1;
                                next_s.oob  = 1'b1;
                            end else begin
                                next_s.trim = trimSum[DFCT_TRIM_W-1:0];
                            end
                        end
                    end
                end
                if (adjust) begin
                    next_s.chill = 1'b1;
                end
                next_s.lastFast = fast;
            end
        end

        // ------------------------------------------------------------
        // Interrupt request on rising flags
        // ------------------------------------------------------------
        next_s.irq = (next_s.roughLocked & ~s.roughLocked & s.irqEn[DFCT_IE_ROUGH]) |
                     (next_s.trimLocked & ~s.trimLocked & s.irqEn[DFCT_IE_TRIM]) |
                     (next_s.refStopped & ~s.refStopped & s.irqEn[DFCT_IE_REFSTOP]);

        // ------------------------------------------------------------
        // Synchronous reset, open loop with default tuning
        // ------------------------------------------------------------
        if (rst) begin
            // Everything else, flags and counters included, comes up clear
            next_s           = '0;
            next_s.stage     = DFCT_OPEN;
            next_s.rough     = DFCT_ROUGH_RST;
            next_s.trim      = DFCT_TRIM_RST;
            next_s.ctrl      = DFCT_CTRL_RST;
            next_s.mul       = DFCT_MUL_RST;
            next_s.roughStep = DFCT_ROUGH_W'(1);
            next_s.trimStep  = DFCT_TRIM_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Reset is folded into the next state, so one plain register stage
    always_ff @(posedge clock) begin
        s <= next_s;
    end

    assign prdata         = s.prdata;
    assign oscEnable      = s.ctrl[DFCT_CTRL_ENABLE];
    assign roughTuneValue = s.rough;
    assign trimTuneValue  = s.trim;
    assign irqRequest     = s.irq;

endmodule

// [test/dfct_ref_model.sv]
// Partner model: the reference clock channel feeding the tuner.
// Assumes it is paced by the tuner clock; halfPeriod counts tuner cycles.
`timescale 1ns/1ps
module dfct_ref_model (
    input  wire logic        clock,
    input  wire logic        run,
    input  wire logic [15:0] halfPeriod,
    output logic             refClk
);
    logic [15:0] count;

    initial begin
        refClk = 1'b0;
        count = 16'h0000;
    end

    // ------------------------------------------------------------
    // Steady reference, one channel only
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (!run) begin
            // Stopped channel idles low, no stray edge
            refClk <= 1'b0;
            count <= 16'h0000;
        end else if (count >= halfPeriod - 16'h0001) begin
            refClk <= ~refClk;
            count <= 16'h0000;
        end else begin
            count <= count + 16'h0001;
        end
    end
endmodule

// [test/dfct_tuner_assertions.sv]
// Checker for the tuner's bus port and tuning outputs.
// Assumes it is bound into dfct_tuner and sees only its ports.
`timescale 1ns/1ps
module dfct_chk
    import dfct_pkg::*;
#(
    parameter int REF_STOP_CYCLES = dfct_pkg::DFCT_REF_STOP_CYCLES
) (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        tunerReferenceClock,
    input wire logic        oscEnable,
    input wire logic [5:0]  roughTuneValue,
    input wire logic [9:0]  trimTuneValue,
    input wire logic        irqRequest
);
    import dfct_pkg::*;
    logic ctrlWr;
    logic valWr;
    logic closedSel;

    // ------------------------------------------------------------
    // Shadow of the closed-loop select bit
    // ------------------------------------------------------------
    assign ctrlWr = psel && penable && pwrite && paddr == DFCT_OFS_CTRL;
    assign valWr = psel && penable && pwrite && paddr == DFCT_OFS_VAL;
    always_ff @(posedge clock) begin
        if (rst) begin
            closedSel <= 1'b0;
        end else if (ctrlWr) begin
            closedSel <= pwdata[DFCT_CTRL_CLOSED];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_ready;
        pready == (psel && penable);
    endproperty
    a_ready: assert property (p_ready) else $error("pready not tied to access phase");
    property p_err;
        psel && penable && paddr > DFCT_OFS_IRQCLR |-> pslverr && prdata == 32'h0000_0000;
    endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_noerr;
        psel && penable && paddr == DFCT_OFS_VAL |-> !pslverr;
    endproperty
    a_noerr: assert property (p_noerr) else $error("mapped access refused");
    property p_rst_vals;
        $fell(rst) |-> roughTuneValue == DFCT_ROUGH_RST && trimTuneValue == DFCT_TRIM_RST && !oscEnable && !irqRequest;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("wrong state after reset");
    property p_en_wr;
        ctrlWr |=> oscEnable == $past(pwdata[DFCT_CTRL_ENABLE]);
    endproperty
    a_en_wr: assert property (p_en_wr) else $error("enable bit not taken");
    property p_en_hold;
        !ctrlWr |=> $stable(oscEnable);
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable changed without write");
    property p_val_wr;
        valWr && !closedSel |=> roughTuneValue == $past(pwdata[15:10]) && trimTuneValue == $past(pwdata[9:0]);
    endproperty
    a_val_wr: assert property (p_val_wr) else $error("open loop value write lost");
    property p_open_hold;
        !closedSel && !valWr |=> $stable(roughTuneValue) && $stable(trimTuneValue);
    endproperty
    a_open_hold: assert property (p_open_hold) else $error("tuning moved in open loop");
    property p_irq_pulse;
        irqRequest |=> !irqRequest;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt not a single pulse");
endmodule

bind dfct_tuner dfct_chk #(.REF_STOP_CYCLES(REF_STOP_CYCLES)) uChk (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tunerReferenceClock(tunerReferenceClock), .oscEnable(oscEnable),
    .roughTuneValue(roughTuneValue), .trimTuneValue(trimTuneValue), .irqRequest(irqRequest)
);

// [test/testbench.sv]
// Self-checking bench for the closed-loop tuner, driven over APB.
// Assumes a 50 MHz tuner clock and a slow reference from the partner model.
`timescale 1ns/1ps
module testbench;
    import dfct_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        refClk;
    logic        refRun = 1'b0;
    logic [15:0] halfPeriod = 16'h0014;
    logic        oscEnable;
    logic [5:0]  roughTuneValue;
    logic [9:0]  trimTuneValue;
    logic        irqRequest;
    logic [31:0] lastData;
    logic        lastErr;
    int          errors = 0;
    int          n_checks = 0;
    int          irqCount = 0;

    always #10 clock = ~clock;
    always @(posedge clock) if (irqRequest === 1'b1) irqCount <= irqCount + 1;

    dfct_ref_model uRef (.clock(clock), .run(refRun), .halfPeriod(halfPeriod), .refClk(refClk));
    dfct_tuner #(.REF_STOP_CYCLES(64)) DUT (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tunerReferenceClock(refClk), .oscEnable(oscEnable), .roughTuneValue(roughTuneValue),
        .trimTuneValue(trimTuneValue), .irqRequest(irqRequest)
    );

    // ------------------------------------------------------------
    // Bus tasks and verdict
    // ------------------------------------------------------------
    task automatic end_sim;
        if (errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
        n_checks++;
        if ((got & mask) !== exp) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, exp, got & mask);
        end
    endtask
    // Idle edge after release so back-to-back calls never double-drive
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        lastData = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
        xfer(a, 1'b0, 32'h0);
        chk(nm, lastData, exp, mask);
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        end_sim;
    end

    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd("ctrl", DFCT_OFS_CTRL, 32'h0, ALL);
        rd("val", DFCT_OFS_VAL, 32'h0000_7DFF, ALL);
        rd("status", DFCT_OFS_STATUS, 32'h0, ALL);
        rd("unmapped", 8'h18, 32'h0, ALL);
        chk("slverr", {31'h0, lastErr}, 32'h1, ALL);
        wr(DFCT_OFS_IRQSET, 32'h7);
        wr(DFCT_OFS_IRQCLR, 32'h4);
        rd("irqen", DFCT_OFS_IRQSET, 32'h3, ALL);
        wr(DFCT_OFS_IRQSET, 32'h4);
        wr(DFCT_OFS_VAL, 32'h0000_8100);
        rd("preload", DFCT_OFS_VAL, 32'h0000_8100, ALL);
        wr(DFCT_OFS_MUL, 32'h2040_0028);
        refRun <= 1'b1;
        wr(DFCT_OFS_CTRL, 32'h1);
        repeat (12) @(posedge clock);
        rd("ready", DFCT_OFS_STATUS, 32'h1, ALL);
        wr(DFCT_OFS_CTRL, 32'h3);
        repeat (800) @(posedge clock);
        rd("locked", DFCT_OFS_STATUS, 32'h19, ALL);
        rd("diff", DFCT_OFS_VAL, 32'h0, 32'hFFFF_0000);
        chk("irqs", irqCount, 32'h2, ALL);
        wr(DFCT_OFS_VAL, 32'h0);
        rd("readonly", DFCT_OFS_VAL, 32'h0000_8000, 32'h0000_FC00);
        halfPeriod <= 16'h0015;
        repeat (400) @(posedge clock);
        rd("track", DFCT_OFS_STATUS, 32'h19, ALL);
        rd("drift", DFCT_OFS_VAL, 32'h0002_0000, 32'hFFFF_0000);
        refRun <= 1'b0;
        repeat (120) @(posedge clock);
        rd("refstop", DFCT_OFS_VAL, 32'h0002_0000, 32'hFFFF_0000);
        repeat (100) @(posedge clock);
        rd("frozen", DFCT_OFS_VAL, lastData & 32'h3FF, 32'h3FF);
        rd("stopflag", DFCT_OFS_STATUS, 32'h2, 32'h2);
        chk("irqs", irqCount, 32'h3, ALL);
        refRun <= 1'b1;
        repeat (200) @(posedge clock);
        rd("refback", DFCT_OFS_STATUS, 32'h0, 32'h2);
        wr(DFCT_OFS_CTRL, 32'h2);
        rd("keep", DFCT_OFS_STATUS, 32'h18, 32'h18);
        wr(DFCT_OFS_CTRL, 32'h23);
        wr(DFCT_OFS_CTRL, 32'h22);
        rd("drop", DFCT_OFS_STATUS, 32'h0, 32'h18);
        wr(DFCT_OFS_CTRL, 32'h1);
        wr(DFCT_OFS_CTRL, 32'h43);
        repeat (3) @(posedge clock);
        rd("bypass", DFCT_OFS_STATUS, 32'h10, 32'h18);
        wr(DFCT_OFS_CTRL, 32'h1);
        wr(DFCT_OFS_MUL, 32'h21FF_0014);
        wr(DFCT_OFS_VAL, 32'h0000_81FF);
        wr(DFCT_OFS_CTRL, 32'h3);
        repeat (1000) @(posedge clock);
        rd("oob", DFCT_OFS_STATUS, 32'h4, 32'h4);
        wr(DFCT_OFS_CTRL, 32'h1);
        wr(DFCT_OFS_STATUS, 32'h4);
        rd("oobclr", DFCT_OFS_STATUS, 32'h0, 32'h4);
        wr(DFCT_OFS_MUL, 32'h2040_0028);
        wr(DFCT_OFS_CTRL, 32'h13);
        repeat (400) @(posedge clock);
        rd("strict", DFCT_OFS_STATUS, 32'h10, 32'h18);
        wr(DFCT_OFS_CTRL, 32'h1);
        wr(DFCT_OFS_VAL, 32'h0000_8100);
        wr(DFCT_OFS_CTRL, 32'hF);
        repeat (400) @(posedge clock);
        rd("hold", DFCT_OFS_VAL, 32'h0002_8100, ALL);
        rd("holdlock", DFCT_OFS_STATUS, 32'h18, 32'h18);
        end_sim;
    end
endmodule
